// ==== core/scj_pkg.sv ====
// Purpose: Shared constants for the drop bus phase indicator block
// Assumes: 250 MHz system clock, one drop bus channel per instance
// Notes:   Byte slot timing is derived from the nominal drop byte period
package scj_pkg;

  // Drop data bus and tag layout
  localparam int DATA_W        = 8;
  localparam int TAG_W         = 3;
  localparam int WORD_W        = DATA_W + TAG_W;
  localparam int TAG_TOH_BIT   = 8;
  localparam int TAG_C1_BIT    = 9;
  localparam int TAG_J1_BIT    = 10;
  localparam int FIFO_DEPTH    = 4;

  // Timing: clock period and drop bus byte period, both in ns
  localparam int CLK_PERIOD_NS  = 4;
  localparam int BYTE_PERIOD_NS = 154;
  localparam int SLOT_CYCLES    = (BYTE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CYCLES    = SLOT_CYCLES / 2;
  localparam int CNT_W          = 6;

  // Values after reset
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;

  // Output stage states, Gray coded
  typedef enum logic [1:0] {
    SCJ_IDLE = 2'b00,
    SCJ_RUN  = 2'b01
  } scj_state_t;

endpackage

// ==== core/scj_fifo.sv ====
// Purpose: Small flip-flop FIFO between byte source and drop bus stage
// Assumes: Single clock, synchronous active high reset
// Notes:   Full and empty come from a true occupancy count
module scj_fifo
  import scj_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [PW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [PW:0]      count_r, count_nxt;
  logic             doWr;
  logic             doRd;

  // Wrap an index at the buffer depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  // Handshakes are combinational from the count
  assign inReady  = (count_r != (PW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  // Next pointers, occupancy and storage
  always_comb begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (doWr) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt        = bump(wrPtr_r);
    end
    if (doRd) begin
      rdPtr_nxt = bump(rdPtr_r);
    end
    if (doWr && !doRd) begin
      count_nxt = count_r + 1'b1;
    end else if (doRd && !doWr) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Register only; storage needs no reset
  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

endmodule

// ==== core/scj_drop_indicator.sv ====
// Purpose: Drop bus byte output with payload and C1/J1 phase indicators
// Assumes: Source tags each byte as overhead, C1 or J1; one clock domain
// Notes:   Shared pin carries the line clock while the bus is disabled
// Notes on behaviour
// - Shared pin is phase indicator when bus enabled
// - Disabled bus: shared pin drives transmit line clock
// - Phase indicator pulses high on C1 byte
// - Phase indicator pulses high on J1 byte
// - C1 pulse one bus period, payload low
// - J1 pulse one bus period, payload high
// - Payload low for overhead and C1, else high
module scj_drop_indicator
  import scj_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              busEnable,
  input  wire logic              txLineClockIn,
  input  wire logic [DATA_W-1:0] srcData,
  input  wire logic              srcIsToh,
  input  wire logic              srcIsC1,
  input  wire logic              srcIsJ1,
  input  wire logic              srcValid,
  output logic                   srcReady,
  output logic      [DATA_W-1:0] drop_data_bus,
  output logic                   drop_payload_ind,
  output logic                   drop_bus_clock,
  output logic                   sharedPinOut
);

  logic [WORD_W-1:0] fifoIn;
  logic [WORD_W-1:0] fifoOut;
  logic              fifoValid;
  logic              fifoPop;

  logic [CNT_W-1:0]  slotCnt_r, slotCnt_nxt;
  logic              slotStart;
  logic              busClk_r, busClk_nxt;

  scj_state_t        state_r, state_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic              payload_r, payload_nxt;
  logic              phase_r, phase_nxt;
  logic              lineClk_r, lineClk_nxt;
  logic              shared_r, shared_nxt;

  // Tags packed beside the byte so they travel in step with it
  assign fifoIn = {srcIsJ1, srcIsC1, srcIsToh, srcData};

  scj_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inData   (fifoIn),
    .inValid  (srcValid),
    .inReady  (srcReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // One byte leaves per slot; a slow slot rate back-pressures the source
  assign slotStart = (slotCnt_r == CNT_W'(SLOT_CYCLES - 1));
  assign fifoPop   = slotStart && fifoValid && busEnable;

  // Byte slot divider and drop bus clock
  always_comb begin
    slotCnt_nxt = slotStart ? CNT_RST : slotCnt_r + 1'b1;
    // Rises mid-slot so the receiver samples a settled byte
    busClk_nxt  = (slotCnt_nxt >= CNT_W'(HALF_CYCLES));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slotCnt_r <= CNT_RST;
      busClk_r  <= 1'b0;
    end else begin
      slotCnt_r <= slotCnt_nxt;
      busClk_r  <= busClk_nxt;
    end
  end

  // Byte output stage; indicators change only at slot boundaries
  always_comb begin
    state_nxt   = state_r;
    data_nxt    = data_r;
    payload_nxt = payload_r;
    phase_nxt   = phase_r;
    if (slotStart) begin
      phase_nxt = 1'b0;
      case (state_r)
        SCJ_IDLE: begin
          payload_nxt = 1'b0;
          if (fifoPop) begin
            state_nxt = SCJ_RUN;
          end
        end
        SCJ_RUN: begin
          if (!busEnable) begin
            state_nxt   = SCJ_IDLE;
            payload_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = SCJ_IDLE;
        end
      endcase
      if (fifoPop) begin
        data_nxt    = fifoOut[DATA_W-1:0];
        payload_nxt = !fifoOut[TAG_TOH_BIT];
        if (fifoOut[TAG_C1_BIT]) begin
          phase_nxt   = 1'b1;
          payload_nxt = 1'b0;
        end else if (fifoOut[TAG_J1_BIT]) begin
          phase_nxt   = 1'b1;
          payload_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r   <= SCJ_IDLE;
      data_r    <= DATA_RST;
      payload_r <= 1'b0;
      phase_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      data_r    <= data_nxt;
      payload_r <= payload_nxt;
      phase_r   <= phase_nxt;
    end
  end

  // Shared pin mux, registered so the pin never glitches
  always_comb begin
    lineClk_nxt = txLineClockIn;
    if (busEnable) begin
      shared_nxt = phase_r;
    end else begin
      shared_nxt = lineClk_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lineClk_r <= 1'b0;
      shared_r  <= 1'b0;
    end else begin
      lineClk_r <= lineClk_nxt;
      shared_r  <= shared_nxt;
    end
  end

  // Phase indicator and byte both pass one stage to the pins, keeping them aligned
  logic [DATA_W-1:0] dataOut_r;
  logic              payloadOut_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      dataOut_r    <= DATA_RST;
      payloadOut_r <= 1'b0;
    end else begin
      dataOut_r    <= data_r;
      payloadOut_r <= payload_r;
    end
  end

  assign drop_data_bus    = dataOut_r;
  assign drop_payload_ind = payloadOut_r;
  assign drop_bus_clock   = busClk_r;
  assign sharedPinOut     = shared_r;

endmodule

// ==== tb/scj_drop_sva.sv ====
// Purpose: Checker for drop bus pins of the phase indicator block
// Assumes: One clock, srst synchronous active high
// Notes:   Bound to the top module; counters saturate
module scj_drop_sva
  import scj_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              busEnable,
  input wire logic              txLineClockIn,
  input wire logic              srcValid,
  input wire logic              srcReady,
  input wire logic [DATA_W-1:0] drop_data_bus,
  input wire logic              drop_payload_ind,
  input wire logic              sharedPinOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] offCnt_r, offCnt_nxt;
  logic [7:0] idleCnt_r, idleCnt_nxt;
  // Time disabled, and time enabled with no source traffic
  always_comb begin
    offCnt_nxt  = busEnable ? 6'h00 : offCnt_r + {5'h00, offCnt_r != 6'h3F};
    idleCnt_nxt = (!busEnable || srcValid) ? 8'h00 : idleCnt_r + {7'h00, idleCnt_r != 8'hFF};
  end
  always_ff @(posedge clk) begin
    offCnt_r  <= srst ? 6'h00 : offCnt_nxt;
    idleCnt_r <= srst ? 8'h00 : idleCnt_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Mux select lags, so only trust the pin after steady enable
  sequence enSteady; busEnable[*4]; endsequence
  sequence pulseBody; sharedPinOut[*8] ##31 sharedPinOut; endsequence
  a_line_clk_fwd: assert property (offCnt_r >= 6'h03 |-> sharedPinOut == $past(txLineClockIn, 2))
    else $error("line clock not forwarded");
  a_pulse_one_slot: assert property (disable iff (srst || !busEnable)
    enSteady ##0 $rose(sharedPinOut) |-> pulseBody) else $error("phase pulse too short");
  a_phase_slot_hold: assert property (disable iff (srst || !busEnable)
    enSteady ##0 $changed(sharedPinOut) |=> $stable(sharedPinOut)[*8]) else $error("phase glitch");
  a_data_slot_hold: assert property ($changed(drop_data_bus) |=> $stable(drop_data_bus)[*8])
    else $error("data byte glitch");
  a_payload_hold: assert property ($changed(drop_payload_ind) |=> $stable(drop_payload_ind)[*8])
    else $error("payload glitch");
  a_off_payload_low: assert property (offCnt_r >= 6'h2A |-> !drop_payload_ind)
    else $error("payload high while disabled");
  a_idle_phase_low: assert property (idleCnt_r >= 8'hFA |-> !sharedPinOut)
    else $error("phase high while idle");
  a_ready_after_rst: assert property ($fell(srst) |-> srcReady)
    else $error("not ready after reset");
endmodule

bind scj_drop_indicator scj_drop_sva u_sva (.clk(clk), .srst(srst), .busEnable(busEnable),
  .txLineClockIn(txLineClockIn), .srcValid(srcValid), .srcReady(srcReady),
  .drop_data_bus(drop_data_bus), .drop_payload_ind(drop_payload_ind), .sharedPinOut(sharedPinOut));

// ==== tb/scj_drop_sink.sv ====
// Purpose: Drop side receiver sampling the bus once per byte slot
// Assumes: Pins settled at the bus clock rise, mid slot
// Notes:   Word packs data, payload and phase
module scj_drop_sink
  import scj_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              drop_bus_clock,
  input  wire logic [DATA_W-1:0] drop_data_bus,
  input  wire logic              drop_payload_ind,
  input  wire logic              sharedPinOut,
  output logic                   got,
  output logic      [DATA_W+1:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busClkQ;
  // Edge detect on the bus clock; sampling mid slot avoids byte edges
  always @(posedge clk) begin
    busClkQ <= drop_bus_clock;
    got     <= drop_bus_clock && !busClkQ;
    word    <= {drop_data_bus, drop_payload_ind, sharedPinOut};
  end
endmodule

// ==== tb/scj_drop_indicator_tb.sv ====
// Purpose: Random byte stream through the drop indicator block
// Assumes: First byte is C1 so the sink knows where the stream starts
// Notes:   Source outruns the slot rate, so the FIFO fills and refuses
module scj_drop_indicator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scj_pkg::*;
  logic clk = 1'b0, srst = 1'b1, busEnable = 1'b1, lineClk = 1'b0, isToh = 1'b0;
  logic isC1 = 1'b0, isJ1 = 1'b0, srcValid = 1'b0, srcReady, payload, busClk, pin, got;
  logic [DATA_W-1:0] srcData = 8'h00, dropData;
  logic [DATA_W+1:0] word;
  logic [DATA_W+1:0] expQ[$];
  logic [1:0] hist = 2'h0;
  int seed = 32'hd49a, errors = 0, cmp_count = 0, cycles = 0;
  bit run = 0;
  always #2 clk = ~clk;
  scj_drop_indicator u_dut (.clk(clk), .srst(srst), .busEnable(busEnable),
    .txLineClockIn(lineClk), .srcData(srcData), .srcIsToh(isToh), .srcIsC1(isC1),
    .srcIsJ1(isJ1), .srcValid(srcValid), .srcReady(srcReady), .drop_data_bus(dropData),
    .drop_payload_ind(payload), .drop_bus_clock(busClk), .sharedPinOut(pin));
  scj_drop_sink u_sink (.clk(clk), .drop_bus_clock(busClk), .drop_data_bus(dropData),
    .drop_payload_ind(payload), .sharedPinOut(pin), .got(got), .word(word));
  task automatic conclude();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Kind: 0 payload byte, 1 overhead, 2 C1, 3 J1
  function automatic logic [9:0] expWord(logic [7:0] d, logic [1:0] k);
    return {d, k != 2'h1 && k != 2'h2, k[1]};
  endfunction
  // Hold the word until the FIFO has room
  task automatic send(logic [7:0] d, logic [1:0] k);
    srcData = d;
    isToh = (k == 2'h1);
    isC1 = (k == 2'h2);
    isJ1 = (k == 2'h3);
    srcValid = 1'b1;
    expQ.push_back(expWord(d, k));
    while (srcReady !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask
  always @(posedge clk) begin
    cycles++;
    // Ceiling well above the ~1600 cycles the scenarios need
    if (cycles == 4000) begin
      errors++;
      conclude();
    end else if (got === 1'b1 && (run || word[0] === 1'b1) && expQ.size() > 0) begin
      run = 1;
      check("drop word", word, expQ.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    send(8'h5A, 2'h2);
    send(8'h3C, 2'h3);
    send(8'hC3, 2'h2);
    for (int i = 0; i < 30; i++) send(8'($random(seed)), 2'($random(seed)));
    srcValid = 1'b0;
    repeat (300) @(posedge clk);
    wait (got === 1'b1);
    check("idle phase", {9'h0, word[0]}, 10'h0);
    check("bytes left", 10'(expQ.size()), 10'h0);
    #1 busEnable = 1'b0;
    repeat (60) @(posedge clk);
    #1 check("payload off", {9'h0, payload}, 10'h0);
    for (int i = 0; i < 40; i++) begin
      hist = {hist[0], lineClk};
      check("line clock", {9'h0, pin}, {9'h0, hist[1]});
      lineClk = 1'($random(seed));
      @(posedge clk) #1;
    end
    conclude();
  end
endmodule
